// ### core/srr_defines.svh
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH
// Command encodings on the decoded command port
`define SRR_CMD_W 3
`define SRR_CMD_DES 3'h0
`define SRR_CMD_MRS 3'h1
`define SRR_CMD_ACT 3'h2
`define SRR_CMD_WR 3'h3
`define SRR_CMD_PRE 3'h4
`define SRR_CMD_REF 3'h5
`define SRR_CMD_OTH 3'h6
// Mode register select codes and fields
`define SRR_MR_ZERO 3'h0
`define SRR_MR_FOUR 3'h4
`define SRR_EN_BIT 5
// Guard key patterns on A11..A7, A6..A0 all ones
`define SRR_KEY1 5'h19
`define SRR_KEY2 5'h0f
`define SRR_KEY3 5'h17
`define SRR_KEY4 5'h07
`define SRR_KEY_LOW 7'h7f
// Burst shape: eight beats over four clocks, deselect after two
`define SRR_BURST_BEATS 4'h8
`define SRR_DESEL_BEATS 4'h4
`define SRR_NBANKS 16
// Write latency default in clocks
`define SRR_WL_DEF 8'h0b
// Register port offsets
`define SRR_A_CTRL 4'h0
`define SRR_A_STAT 4'h1
`define SRR_A_WL 4'h2
`define SRR_A_SEED 4'h3
`define SRR_A_BANKS 4'h4
`endif

// ### core/srr_pkg.sv
package srr_pkg;
  typedef enum logic [5:0] {
    SRR_IDLE = 6'h01,
    SRR_KEYS = 6'h02,
    SRR_ARMED = 6'h04,
    SRR_WAITWR = 6'h08,
    SRR_BURST = 6'h10,
    SRR_PRECH = 6'h20
  } srr_state_t;
endpackage

// ### core/srr_burst_if.sv
`timescale 1ns/100ps
interface srr_burst_if;
  logic start;
  logic [7:0] wl;
  logic beat_low;
  logic beat_high;
  logic done;
  logic repair;
  logic keep;
  modport ctl (output start, output wl, output beat_low, output beat_high,
    input done, input repair, input keep);
  modport chk (input start, input wl, input beat_low, input beat_high,
    output done, output repair, output keep);
endinterface

// ### core/srr_burst_check.sv
`timescale 1ns/100ps
`include "srr_defines.svh"
module srr_burst_check (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link to the sequencer
  srr_burst_if.chk bi
);
  logic [7:0] lat_q;
  logic [3:0] beat_q;
  logic busy_q;
  logic inburst_q;
  logic all_low_q;
  logic all_high_q;
  logic done_q;
  logic repair_q;
  logic keep_q;

  // Waits write latency then watches eight beats, two per clock
  always_ff @(posedge mclk) begin
    done_q <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
      inburst_q <= 1'b0;
      lat_q <= 8'h00;
      beat_q <= 4'h0;
      all_low_q <= 1'b1;
      all_high_q <= 1'b1;
      repair_q <= 1'b0;
      keep_q <= 1'b0;
    end else if (bi.start) begin
      busy_q <= 1'b1;
      inburst_q <= 1'b0;
      lat_q <= bi.wl;
      beat_q <= 4'h0;
      all_low_q <= 1'b1;
      all_high_q <= 1'b1;
    end else if (busy_q && !inburst_q) begin
      if (lat_q <= 8'h01) begin
        inburst_q <= 1'b1;
      end else begin
        lat_q <= lat_q - 8'h01;
      end
    end else if (inburst_q) begin
      all_low_q <= all_low_q & bi.beat_low;
      if (beat_q < `SRR_DESEL_BEATS) begin
        all_high_q <= all_high_q & bi.beat_high;
      end
      beat_q <= beat_q + 4'h2;
      if (beat_q + 4'h2 == `SRR_BURST_BEATS) begin
        busy_q <= 1'b0;
        inburst_q <= 1'b0;
        done_q <= 1'b1;
        repair_q <= all_low_q & bi.beat_low;
        keep_q <= all_high_q;
      end
    end
  end

  assign bi.done = done_q;
  assign bi.repair = repair_q;
  assign bi.keep = keep_q;

  // An all-high start must never also count as a repair
  a_keep_or_repair: assert property (@(posedge mclk) disable iff (rst)
    done_q |-> !(repair_q && keep_q))
    else $error("keep and repair both flagged");
endmodule

// ### core/srr_seq.sv
// What this block does
// - Mode register four bit five set requests repair mode; clear disables. The code ignores a clear while in SRR_BURST.
// - DQ lines held high when the enable write is issued.
// - Guard keys use bank zero, low bits ones, fixed A11..A7 patterns.
// - Out-of-order or interrupted keys leave repair disabled, a no-op. With legacy_q set, the code skips the keys and goes straight to SRR_ARMED.
// - After failed entry, activate and write act as ordinary accesses.
// - Repair only if all DQ low for all eight burst beats.
// - Any high DQ in the burst deselects the device, no repair.
// - All high for two clocks keeps data; other patterns undefined.
// - Associated rows differ from seed only in BA0, A17..A13, A1, A0.
// - Other rows of the repaired bank keep their data.
// - One repair per bank; later repair replaces; reset clears all.
// - Sequence to a bank without repair resource is ignored.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "srr_defines.svh"
module srr_seq (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Decoded command and address bus
  input wire logic [2:0] cmd,
  input wire logic [2:0] mr_sel,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  // Burst beat summary, two beats per clock
  input wire logic dq_all_low,
  input wire logic dq_all_high,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Device status
  output logic repair_mode,
  output logic dq_hold_high,
  output logic row_swap,
  output logic [3:0] swap_bank,
  output logic [17:0] swap_row,
  output logic [17:0] assoc_mask
);
  srr_pkg::srr_state_t st_q;
  logic [1:0] key_q;
  logic [3:0] bank_q;
  logic [17:0] seed_q;
  logic [7:0] wl_q;
  logic legacy_q;
  logic [15:0] avail_q;
  logic [15:0] valid_q;
  logic [17:0] row_mem_q [0:`SRR_NBANKS-1];
  logic [15:0] rdata_q;
  logic swap_q;
  logic [2:0] cnt_ok_q;
  logic [2:0] cnt_bad_q;
  logic mr4_wr;
  logic mr0_wr;
  logic key_hit;
  srr_burst_if bi ();

  // Guard key pattern for a given step
  function automatic logic [4:0] key_pat(input logic [1:0] k);
    logic [4:0] p;
    p = `SRR_KEY1;
    unique case (k)
      2'd0: p = `SRR_KEY1;
      2'd1: p = `SRR_KEY2;
      2'd2: p = `SRR_KEY3;
      2'd3: p = `SRR_KEY4;
    endcase
    return p;
  endfunction

  assign mr4_wr = (cmd == `SRR_CMD_MRS) && (mr_sel == `SRR_MR_FOUR);
  assign mr0_wr = (cmd == `SRR_CMD_MRS) && (mr_sel == `SRR_MR_ZERO);
  // Key must be bank zero, low bits ones, and the expected pattern
  assign key_hit = mr0_wr && (bg == 2'b00) && (ba == 2'b00)
    && (addr[6:0] == `SRR_KEY_LOW) && (addr[11:7] == key_pat(key_q));

  // Repair sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= srr_pkg::SRR_IDLE;
      key_q <= 2'd0;
      bank_q <= 4'h0;
      seed_q <= 18'h00000;
    end else begin
      unique case (st_q)
        srr_pkg::SRR_IDLE: begin
          if (mr4_wr && addr[`SRR_EN_BIT]) begin
            st_q <= legacy_q ? srr_pkg::SRR_ARMED : srr_pkg::SRR_KEYS;
            key_q <= 2'd0;
          end
        end
        srr_pkg::SRR_KEYS: begin
          if (mr4_wr && !addr[`SRR_EN_BIT]) begin
            st_q <= srr_pkg::SRR_IDLE;
          end else if (key_hit) begin
            key_q <= key_q + 2'd1;
            if (key_q == 2'd3) begin
              st_q <= srr_pkg::SRR_ARMED;
            end
          end else if (cmd != `SRR_CMD_DES) begin
            st_q <= srr_pkg::SRR_IDLE;
          end
        end
        srr_pkg::SRR_ARMED: begin
          if (cmd == `SRR_CMD_ACT) begin
            bank_q <= {bg, ba};
            seed_q <= addr;
            st_q <= srr_pkg::SRR_WAITWR;
          end else if (mr4_wr && !addr[`SRR_EN_BIT]) begin
            st_q <= srr_pkg::SRR_IDLE;
          end
        end
        srr_pkg::SRR_WAITWR: begin
          if (cmd == `SRR_CMD_WR && {bg, ba} == bank_q) begin
            st_q <= srr_pkg::SRR_BURST;
          end else if (mr4_wr && !addr[`SRR_EN_BIT]) begin
            st_q <= srr_pkg::SRR_IDLE;
          end
        end
        srr_pkg::SRR_BURST: begin
          if (bi.done) begin
            st_q <= srr_pkg::SRR_PRECH;
          end
        end
        srr_pkg::SRR_PRECH: begin
          if (mr4_wr && !addr[`SRR_EN_BIT]) begin
            st_q <= srr_pkg::SRR_IDLE;
          end
        end
        default: st_q <= srr_pkg::SRR_IDLE;
      endcase
    end
  end

  assign bi.start = (st_q == srr_pkg::SRR_WAITWR) && (cmd == `SRR_CMD_WR)
    && ({bg, ba} == bank_q);
  assign bi.wl = wl_q;
  assign bi.beat_low = dq_all_low;
  assign bi.beat_high = dq_all_high;

  srr_burst_check u_burst (
    .mclk(mclk),
    .rst(rst),
    .bi(bi)
  );

  // Per-bank repair store, cleared by reset
  always_ff @(posedge mclk) begin
    swap_q <= 1'b0;
    if (rst) begin
      valid_q <= 16'h0000;
      for (int i = 0; i < `SRR_NBANKS; i++) begin
        row_mem_q[i] <= 18'h00000;
      end
    end else if (bi.done && bi.repair && avail_q[bank_q]) begin
      valid_q[bank_q] <= 1'b1;
      row_mem_q[bank_q] <= seed_q;
      swap_q <= 1'b1;
    end
  end

  // Outcome counters for software
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_ok_q <= 3'h0;
      cnt_bad_q <= 3'h0;
    end else if (bi.done) begin
      if (bi.repair && avail_q[bank_q]) begin
        cnt_ok_q <= cnt_ok_q + 3'h1;
      end else begin
        cnt_bad_q <= cnt_bad_q + 3'h1;
      end
    end
  end

  // Register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      legacy_q <= 1'b0;
      wl_q <= `SRR_WL_DEF;
      avail_q <= 16'hffff;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `SRR_A_CTRL: legacy_q <= reg_wdata[0];
        `SRR_A_WL: wl_q <= reg_wdata[7:0];
        `SRR_A_BANKS: avail_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SRR_A_CTRL: rdata_q <= {15'h0000, legacy_q};
        `SRR_A_STAT: rdata_q <= {4'h0, cnt_bad_q, cnt_ok_q, st_q};
        `SRR_A_WL: rdata_q <= {8'h00, wl_q};
        `SRR_A_SEED: rdata_q <= {bank_q, seed_q[11:0]};
        `SRR_A_BANKS: rdata_q <= valid_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign repair_mode = (st_q != srr_pkg::SRR_IDLE);
  assign dq_hold_high = (st_q == srr_pkg::SRR_IDLE) && mr4_wr && addr[`SRR_EN_BIT];
  assign row_swap = swap_q;
  assign swap_bank = bank_q;
  assign swap_row = seed_q;
  assign assoc_mask = 18'h3e003;

  a_bad_key_drop: assert property (@(posedge mclk) disable iff (rst)
    (st_q == srr_pkg::SRR_KEYS && !key_hit && !mr4_wr && cmd != `SRR_CMD_DES)
    |=> st_q == srr_pkg::SRR_IDLE)
    else $error("bad key did not abort entry");
  a_key_to_armed: assert property (@(posedge mclk) disable iff (rst)
    (st_q == srr_pkg::SRR_KEYS && key_hit && key_q == 2'd3)
    |=> st_q == srr_pkg::SRR_ARMED)
    else $error("fourth key did not arm");
  a_enable_entry: assert property (@(posedge mclk) disable iff (rst)
    (st_q == srr_pkg::SRR_IDLE && mr4_wr && addr[`SRR_EN_BIT] && !legacy_q)
    |=> st_q == srr_pkg::SRR_KEYS && key_q == 2'd0)
    else $error("enable write not taken");
  a_dq_high: assert property (@(posedge mclk) disable iff (rst)
    (st_q == srr_pkg::SRR_IDLE && mr4_wr && addr[`SRR_EN_BIT]) |-> dq_hold_high ##1 repair_mode)
    else $error("dq not held high on enable");
  a_no_repair_idle: assert property (@(posedge mclk) disable iff (rst)
    (st_q == srr_pkg::SRR_IDLE) |=> !row_swap)
    else $error("repair outside sequence");
  a_swap_needs_low: assert property (@(posedge mclk) disable iff (rst)
    row_swap |-> $past(bi.done) && $past(bi.repair))
    else $error("swap without all-low burst");
  a_high_blocks: assert property (@(posedge mclk) disable iff (rst)
    (bi.done && !bi.repair) |=> !row_swap)
    else $error("repair despite high beat");
  a_full_bank_ign: assert property (@(posedge mclk) disable iff (rst)
    (bi.done && !avail_q[bank_q]) |=> !row_swap && $stable(valid_q))
    else $error("repair on exhausted bank");
endmodule

// ### test/srr_ctl_model.sv
`timescale 1ns/100ps
`include "srr_defines.svh"
module srr_ctl_model (
  // Clock
  input wire logic mclk,
  // Command bus and burst summary
  output logic [2:0] cmd,
  output logic [2:0] mr_sel,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [17:0] addr,
  output logic dq_all_low,
  output logic dq_all_high
);
  // Idle bus, burst lines neither all low nor all high
  initial begin
    cmd = `SRR_CMD_DES;
    mr_sel = 3'h0;
    {bg, ba} = 4'h0;
    addr = 18'h0;
    dq_all_low = 1'b0;
    dq_all_high = 1'b0;
  end

  // One command, then deselect with a scrambled address
  task automatic issue(input logic [2:0] c, input logic [2:0] m, input logic [3:0] bk,
    input logic [17:0] a);
    cmd <= c;
    mr_sel <= m;
    {bg, ba} <= bk;
    addr <= a;
    @(posedge mclk);
    cmd <= `SRR_CMD_DES;
    addr <= ~a;
    repeat (2) @(posedge mclk);
  endtask

  // Whole entry, repair and exit; no refresh anywhere
  task automatic repair(input logic [3:0] bk, input logic [17:0] row, input logic [3:0] lo,
    input logic [3:0] hi, input int wl, input bit keys, input bit bad);
    logic [4:0] k[4];
    k = '{`SRR_KEY1, `SRR_KEY2, `SRR_KEY3, `SRR_KEY4};
    if (bad) k[1] = `SRR_KEY3; // Keys out of order
    issue(`SRR_CMD_MRS, `SRR_MR_FOUR, 4'h0, 18'h00020);
    for (int i = 0; i < 4; i++) if (keys) issue(`SRR_CMD_MRS, `SRR_MR_ZERO, 4'h0,
      {6'h00, k[i], `SRR_KEY_LOW});
    issue(`SRR_CMD_ACT, 3'h0, bk, row);
    issue(`SRR_CMD_WR, 3'h0, bk, 18'h00000);
    repeat (wl - 2) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      dq_all_low <= lo[i];
      dq_all_high <= hi[i];
      @(posedge mclk);
    end
    dq_all_low <= 1'b0;
    dq_all_high <= 1'b0;
    repeat (4) @(posedge mclk);
    issue(`SRR_CMD_PRE, 3'h0, bk, 18'h00000);
    issue(`SRR_CMD_MRS, `SRR_MR_FOUR, 4'h0, 18'h00000);
  endtask
endmodule

// ### test/srr_seq_tb.sv
`timescale 1ns/100ps
`include "srr_defines.svh"
module srr_seq_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cmd, mr_sel;
  logic [1:0] bg, ba;
  logic [17:0] addr, swap_row, assoc_mask, row;
  logic dq_all_low, dq_all_high, repair_mode, dq_hold_high, row_swap;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_v = 1'b0;
  logic [15:0] reg_rdata, rep;
  logic [3:0] swap_bank, bk;
  logic [21:0] swap_q[$];
  logic [15:0] rd_q[$];
  logic [3:0] lo_t[3] = '{4'hf, 4'hb, 4'h0};
  logic [3:0] hi_t[3] = '{4'h0, 4'h0, 4'h3};
  int error_cnt = 0;
  int checked = 0;
  int wl;

  always #20 mclk = ~mclk;

  srr_ctl_model u_ctl (.mclk(mclk), .cmd(cmd), .mr_sel(mr_sel), .bg(bg), .ba(ba),
    .addr(addr), .dq_all_low(dq_all_low), .dq_all_high(dq_all_high));
  srr_seq u_dut (.mclk(mclk), .rst(rst), .cmd(cmd), .mr_sel(mr_sel), .bg(bg), .ba(ba),
    .addr(addr), .dq_all_low(dq_all_low), .dq_all_high(dq_all_high),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .repair_mode(repair_mode), .dq_hold_high(dq_hold_high),
    .row_swap(row_swap), .swap_bank(swap_bank), .swap_row(swap_row),
    .assoc_mask(assoc_mask));

  // Counted comparison
  task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register port cycles
  task automatic reg_wr_t(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic reg_rd_t(input logic [3:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Output watcher, takes the oldest note per result
  always @(posedge mclk) begin
    rd_v <= reg_rd;
    if (rd_v) check("reg_rdata", {6'h0, rd_q.pop_front()}, {6'h0, reg_rdata});
    if (row_swap === 1'b1) begin
      check("repair_mode", 22'h1, {21'h0, repair_mode});
      if (swap_q.size() == 0) check("row_swap", 22'h0, 22'h1);
      else check("swap", swap_q.pop_front(), {swap_bank, swap_row});
    end
    if (cmd == `SRR_CMD_MRS && mr_sel == `SRR_MR_FOUR && addr[5] && repair_mode === 1'b0)
      check("dq_hold_high", 22'h1, {21'h0, dq_hold_high});
  end

  // Hang guard
  initial begin
    #(40 * 5000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h87ce89d5));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_rd_t(`SRR_A_WL, 16'h000b);
    reg_rd_t(`SRR_A_STAT, 16'h0001);
    reg_rd_t(`SRR_A_BANKS, 16'h0000);
    reg_rd_t(4'hf, 16'h0000);
    check("assoc_mask", 22'h03e003, {4'h0, assoc_mask});
    wl = 3 + $urandom_range(5);
    reg_wr_t(`SRR_A_WL, wl[15:0]);
    $display("test registers done");
    // Two repairs to one bank, the second replaces
    bk = 4'($urandom);
    rep = 16'h0001 << bk;
    for (int i = 0; i < 2; i++) begin
      row = 18'($urandom);
      swap_q.push_back({bk, row});
      u_ctl.repair(bk, row, 4'hf, 4'h0, wl, 1'b1, 1'b0);
      reg_rd_t(`SRR_A_SEED, {bk, row[11:0]});
    end
    reg_rd_t(`SRR_A_BANKS, rep);
    $display("test repair done");
    // Broken keys, a deselect beat, an all-high start
    for (int i = 0; i < 3; i++)
      u_ctl.repair(bk + 4'h1, 18'($urandom), lo_t[i], hi_t[i], wl, 1'b1, i == 0);
    reg_rd_t(`SRR_A_BANKS, rep);
    $display("test no repair done");
    reg_wr_t(`SRR_A_BANKS, ~(16'h0001 << (bk + 4'h2)));
    u_ctl.repair(bk + 4'h2, 18'h00155, 4'hf, 4'h0, wl, 1'b1, 1'b0);
    reg_rd_t(`SRR_A_BANKS, rep);
    reg_rd_t(`SRR_A_STAT, 16'h0681);
    $display("test no resource done");
    reg_wr_t(`SRR_A_BANKS, 16'hffff);
    reg_wr_t(`SRR_A_CTRL, 16'h0001);
    swap_q.push_back({bk + 4'h3, 18'h2aaaa});
    u_ctl.repair(bk + 4'h3, 18'h2aaaa, 4'hf, 4'h0, wl, 1'b0, 1'b0);
    $display("test legacy done");
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_rd_t(`SRR_A_BANKS, 16'h0000);
    reg_rd_t(`SRR_A_WL, 16'h000b);
    check("repair_mode", 22'h0, {21'h0, repair_mode});
    repeat (4) @(posedge mclk);
    check("pending", 22'h0, 22'(swap_q.size()));
    $display("test reset done");
    tally_and_finish();
  end
endmodule
